// ==== rtl/shrp_buf2.sv ====
module shrp_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);
    // head entry plus one skid entry; ready comes from a flop
    logic         skid_valid_reg;
    logic [W-1:0] skid_data_reg;
    wire          take = in_valid_i && !skid_valid_reg;
    wire          move = out_ready_i || !out_valid_o;

    assign in_ready_o = !skid_valid_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_o    <= 1'b0;
            out_data_o     <= '0;
            skid_valid_reg <= 1'b0;
            skid_data_reg  <= '0;
        end else if (move) begin
            out_valid_o    <= skid_valid_reg || take;
            out_data_o     <= skid_valid_reg ? skid_data_reg : in_data_i;
            skid_valid_reg <= 1'b0;
        end else if (take) begin
            skid_valid_reg <= 1'b1;
            skid_data_reg  <= in_data_i;
        end
    end
endmodule

// ==== rtl/shrp_pkg.sv ====
package shrp_pkg;
    // clock and rate reference, in kHz
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned REF_KHZ = 27120;
    localparam logic [16:0] ACC_MOD = 17'(CLK_KHZ);
    localparam logic [16:0] ACC_INC = 17'(REF_KHZ);
    // uart rate register: exponent [7:5], mantissa [4:0]
    localparam logic [7:0]  RATE_RST   = 8'heb;
    localparam int          EXP_MSB    = 7;
    localparam int          EXP_LSB    = 5;
    localparam int          MANT_MSB   = 4;
    localparam int          MANT_LSB   = 0;
    localparam logic [12:0] MANT_OFS   = 13'h0021;
    localparam logic [12:0] MANT_OFS0  = 13'h0001;
    localparam logic [12:0] DFLT_TICKS = 13'h0b00;
    // address byte layout
    localparam int DIR_BIT    = 7;
    localparam int SPI_A_MSB  = 6;
    localparam int SPI_A_LSB  = 1;
    localparam int UART_A_MSB = 5;
    localparam int UART_A_LSB = 0;
    // bit counts
    localparam logic [2:0] SPI_LAST_BIT  = 3'h7;
    localparam logic [3:0] UART_STOP_IDX = 4'h9;
    // strap capture after reset release
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    // synchroniser lanes and their idle levels
    localparam int         S_SCK    = 0;
    localparam int         S_MOSI   = 1;
    localparam int         S_NSS    = 2;
    localparam int         S_RX     = 3;
    localparam int         S_I2C    = 4;
    localparam int         S_EA     = 5;
    localparam logic [5:0] SYNC_RST = 6'h0c;
    typedef enum logic [2:0] {
        U_ADDR  = 3'b000,
        U_DATA  = 3'b001,
        U_PUSH  = 3'b010,
        U_RWAIT = 3'b011,
        U_TX    = 3'b100
    } shrp_ustate_t;
endpackage

// ==== rtl/shrp_port.sv ====
// Operation
// - device is only an spi slave; master drives clock and mosi
// - spi link runs at most 10 Mbit/s
// - spi bytes travel msb first on both lines
// - device changes miso on falling edge, stable over rising edge
// - read burst: address bytes then 00; data lags one byte behind
// - write: one address byte, then any number of data bytes
// - spi address byte: bit 7 direction, bits 6..1 address, bit 0 zero
// - uart starts at 9.6 kBd after reset
// - rate register holds 3-bit exponent and 5-bit mantissa
// - nonzero exponent: rate is 27.12 MHz/(mantissa+33)/2^(exponent-1)
// - uart character: start 0, eight data bits, stop 1, no parity
// - uart data bits go lsb first both ways
// - uart read: one address character, device answers with register data
// - uart write: address then data; device echoes address as acknowledge
// - uart address: bit 7 direction, bit 6 reserved, bits 5..0 address
// - sideband enable low turns request and auxiliary lines off
// - strap levels sampled after reset choose the active host interface
module shrp_port (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       spi_sck_i,
    input  wire logic       spi_mosi_i,
    input  wire logic       spi_nss_n_i,
    output logic            spi_miso_o,
    input  wire logic       uart_rx_i,
    output logic            uart_tx_o,
    output logic            uart_request_line_o,
    output logic            uart_auxiliary_line_o,
    input  wire logic       uart_sideband_enable_i,
    input  wire logic       strap_i2c_i,
    input  wire logic       strap_ea_i,
    output logic            if_spi_o,
    output logic            if_uart_o,
    input  wire logic       rate_wr_i,
    input  wire logic [7:0] rate_data_i,
    output logic      [7:0] uart_rate_register_o,
    output logic            reg_rd_o,
    output logic      [5:0] reg_rd_addr_o,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_valid_o,
    input  wire logic       reg_wr_ready_i,
    output logic      [5:0] reg_wr_addr_o,
    output logic      [7:0] reg_wr_data_o,
    output logic            wr_drop_o
);
    // all pins come from outside clk_i
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    assign pin_raw = {strap_ea_i, strap_i2c_i, uart_rx_i, spi_nss_n_i, spi_mosi_i, spi_sck_i};

    shrp_sync #(
        .W       (6),
        .RST_VAL (shrp_pkg::SYNC_RST)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_raw),
        .q_o   (pin_s)
    );

    wire sck_s  = pin_s[shrp_pkg::S_SCK];
    wire mosi_s = pin_s[shrp_pkg::S_MOSI];
    wire nss_s  = pin_s[shrp_pkg::S_NSS];
    wire rx_s   = pin_s[shrp_pkg::S_RX];
    wire i2c_s  = pin_s[shrp_pkg::S_I2C];
    wire ea_s   = pin_s[shrp_pkg::S_EA];

    // interface choice; straps are read once the synchroniser has settled
    logic [1:0] strap_cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_cnt_reg <= 2'h0;
            if_spi_o      <= 1'b0;
            if_uart_o     <= 1'b0;
        end else begin
            if (strap_cnt_reg != shrp_pkg::STRAP_DONE) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
            if (strap_cnt_reg == shrp_pkg::STRAP_WAIT) begin
                if_spi_o  <= !i2c_s && ea_s;
                if_uart_o <= !i2c_s && !ea_s;
            end
        end
    end

    // ---- spi side
    logic       sck_q_reg;
    logic       spi_first_reg;
    logic       spi_read_reg;
    logic       spi_rd_pend_reg;
    logic [2:0] spi_bit_reg;
    logic [7:0] spi_rx_reg;
    logic [7:0] spi_tx_reg;
    logic [5:0] spi_addr_reg;
    logic       rd_ack_reg;
    logic       buf_ready;

    wire       spi_act    = if_spi_o && !nss_s;
    wire       sck_rise   = spi_act && sck_s && !sck_q_reg;
    wire       sck_fall   = spi_act && !sck_s && sck_q_reg;
    wire       spi_done   = sck_rise && (spi_bit_reg == shrp_pkg::SPI_LAST_BIT);
    wire [7:0] spi_byte   = {spi_rx_reg[6:0], mosi_s};
    wire       spi_is_rd  = spi_byte[shrp_pkg::DIR_BIT];
    wire [5:0] spi_baddr  = spi_byte[shrp_pkg::SPI_A_MSB:shrp_pkg::SPI_A_LSB];
    // every read-mode byte with the read flag fetches; final 00 does not
    wire       spi_rd_req = spi_done && spi_is_rd && (spi_first_reg || spi_read_reg);
    // later bytes of a write burst all go to the latched address
    wire       spi_push   = spi_done && !spi_first_reg && !spi_read_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q_reg <= 1'b0;
        end else begin
            sck_q_reg <= sck_s;
        end
    end

    // byte assembly; mosi is taken on the rising edge
    // deselect restarts
    always_ff @(posedge clk_i) begin
        if (rst_i || !spi_act) begin
            spi_bit_reg   <= 3'h0;
            spi_first_reg <= 1'b1;
            spi_read_reg  <= 1'b0;
            spi_rx_reg    <= 8'h00;
            spi_addr_reg  <= 6'h00;
        end else if (sck_rise) begin
            spi_rx_reg  <= spi_byte;
            spi_bit_reg <= spi_bit_reg + 3'h1;
            if (spi_done && spi_first_reg) begin
                spi_first_reg <= 1'b0;
                spi_read_reg  <= spi_is_rd;
                spi_addr_reg  <= spi_baddr;
            end
        end
    end

    // miso shift; write bursts and the first byte shift out zeros
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spi_miso_o      <= 1'b0;
            spi_tx_reg      <= 8'h00;
            spi_rd_pend_reg <= 1'b0;
        end else if (!spi_act) begin
            // stale read data must not leak into the next burst
            spi_tx_reg      <= 8'h00;
            spi_rd_pend_reg <= 1'b0;
        end else if (rd_ack_reg && spi_rd_pend_reg) begin
            // data lands well inside the shortest half period
            spi_tx_reg      <= reg_rdata_i;
            spi_rd_pend_reg <= 1'b0;
        end else if (spi_done) begin
            spi_tx_reg      <= 8'h00;
            spi_rd_pend_reg <= spi_rd_req;
        end else if (sck_fall) begin
            spi_miso_o <= spi_tx_reg[7];
            spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
        end
    end

    // ---- uart side
    logic [16:0]                acc_reg;
    logic                       rx_q_reg;
    logic                       rx_busy_reg;
    logic                       rx_done_reg;
    logic [12:0]                rx_cnt_reg;
    logic [3:0]                 rx_idx_reg;
    logic [7:0]                 rx_sh_reg;
    logic                       tx_busy_reg;
    logic [12:0]                tx_cnt_reg;
    logic [3:0]                 tx_idx_reg;
    logic [8:0]                 tx_frame_reg;
    logic [7:0]                 u_addr_reg;
    logic [7:0]                 u_data_reg;
    shrp_pkg::shrp_ustate_t     ustate_reg;
    shrp_pkg::shrp_ustate_t     ustate_next;

    // fractional accumulator gives a 27.12 MHz tick from clk_i; jitter is one clk
    wire [16:0] acc_sum = acc_reg + shrp_pkg::ACC_INC;
    wire        tick    = acc_sum >= shrp_pkg::ACC_MOD;

    // bit period in reference ticks
    wire [2:0]  rate_exp  = uart_rate_register_o[shrp_pkg::EXP_MSB:shrp_pkg::EXP_LSB];
    wire [12:0] rate_mant = 13'(uart_rate_register_o[shrp_pkg::MANT_MSB:shrp_pkg::MANT_LSB]);
    // exponent and mantissa select the divider
    // fastest setting, exponent 0 with mantissa 0, gives only 1 tick
    wire [12:0] bit_ticks = (rate_exp == 3'h0) ? rate_mant + shrp_pkg::MANT_OFS0
                                               : (rate_mant + shrp_pkg::MANT_OFS) << (rate_exp - 3'h1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= 17'h00000;
        end else begin
            acc_reg <= tick ? acc_sum - shrp_pkg::ACC_MOD : acc_sum;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uart_rate_register_o <= shrp_pkg::RATE_RST;
        end else if (rate_wr_i) begin
            uart_rate_register_o <= rate_data_i;
        end
    end

    // receiver: start edge, half a bit, then one sample per bit
    wire rx_start = if_uart_o && !rx_busy_reg && rx_q_reg && !rx_s;
    wire rx_smp   = rx_busy_reg && tick && (rx_cnt_reg == 13'h0000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_q_reg    <= 1'b1;
            rx_busy_reg <= 1'b0;
            rx_done_reg <= 1'b0;
            rx_cnt_reg  <= 13'h0000;
            rx_idx_reg  <= 4'h0;
            rx_sh_reg   <= 8'h00;
        end else begin
            rx_q_reg    <= rx_s;
            rx_done_reg <= 1'b0;
            if (rx_start) begin
                rx_busy_reg <= 1'b1;
                rx_cnt_reg  <= bit_ticks >> 1;
                rx_idx_reg  <= 4'h0;
            end else if (rx_smp) begin
                rx_cnt_reg <= bit_ticks - 13'h0001;
                rx_idx_reg <= rx_idx_reg + 4'h1;
                // glitch start and bad stop are dropped
                if (rx_idx_reg == 4'h0 && rx_s) begin
                    rx_busy_reg <= 1'b0;
                end else if (rx_idx_reg == shrp_pkg::UART_STOP_IDX) begin
                    rx_busy_reg <= 1'b0;
                    rx_done_reg <= rx_s;
                end else if (rx_idx_reg != 4'h0) begin
                    rx_sh_reg <= {rx_s, rx_sh_reg[7:1]};
                end
            end else if (rx_busy_reg && tick) begin
                rx_cnt_reg <= rx_cnt_reg - 13'h0001;
            end
        end
    end

    // command sequencing
    wire       u_dir       = rx_sh_reg[shrp_pkg::DIR_BIT];
    wire       uart_rd_req = (ustate_reg == shrp_pkg::U_ADDR) && rx_done_reg && u_dir;
    // write waits here while the buffer is full, so no word is lost
    wire       uart_push   = (ustate_reg == shrp_pkg::U_PUSH) && buf_ready;
    wire       tx_start    = uart_push || ((ustate_reg == shrp_pkg::U_RWAIT) && rd_ack_reg);
    wire [7:0] tx_byte     = uart_push ? u_addr_reg : reg_rdata_i;

    always_comb begin
        ustate_next = ustate_reg;
        case (ustate_reg)
            shrp_pkg::U_ADDR: begin
                if (rx_done_reg) begin
                    ustate_next = u_dir ? shrp_pkg::U_RWAIT : shrp_pkg::U_DATA;
                end
            end
            shrp_pkg::U_DATA: begin
                if (rx_done_reg) begin
                    ustate_next = shrp_pkg::U_PUSH;
                end
            end
            shrp_pkg::U_PUSH: begin
                if (buf_ready) begin
                    ustate_next = shrp_pkg::U_TX;
                end
            end
            shrp_pkg::U_RWAIT: begin
                if (rd_ack_reg) begin
                    ustate_next = shrp_pkg::U_TX;
                end
            end
            shrp_pkg::U_TX: begin
                if (!tx_busy_reg) begin
                    ustate_next = shrp_pkg::U_ADDR;
                end
            end
            default: begin
                ustate_next = shrp_pkg::U_ADDR;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ustate_reg <= shrp_pkg::U_ADDR;
            u_addr_reg <= 8'h00;
            u_data_reg <= 8'h00;
        end else begin
            ustate_reg <= ustate_next;
            if (ustate_reg == shrp_pkg::U_ADDR && rx_done_reg) begin
                u_addr_reg <= rx_sh_reg;
            end
            if (ustate_reg == shrp_pkg::U_DATA && rx_done_reg) begin
                u_data_reg <= rx_sh_reg;
            end
        end
    end

    // transmitter: start bit, eight data bits, stop bit
    wire tx_end = tx_busy_reg && tick && (tx_cnt_reg == 13'h0000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uart_tx_o    <= 1'b1;
            tx_busy_reg  <= 1'b0;
            tx_cnt_reg   <= 13'h0000;
            tx_idx_reg   <= 4'h0;
            tx_frame_reg <= 9'h1ff;
        end else if (tx_start) begin
            uart_tx_o    <= 1'b0;
            tx_busy_reg  <= 1'b1;
            tx_cnt_reg   <= bit_ticks - 13'h0001;
            tx_idx_reg   <= 4'h0;
            tx_frame_reg <= {1'b1, tx_byte};
        end else if (tx_end) begin
            tx_cnt_reg <= bit_ticks - 13'h0001;
            if (tx_idx_reg == shrp_pkg::UART_STOP_IDX) begin
                tx_busy_reg <= 1'b0;
            end else begin
                uart_tx_o    <= tx_frame_reg[0];
                tx_frame_reg <= {1'b1, tx_frame_reg[8:1]};
                tx_idx_reg   <= tx_idx_reg + 4'h1;
            end
        end else if (tx_busy_reg && tick) begin
            tx_cnt_reg <= tx_cnt_reg - 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uart_request_line_o   <= 1'b0;
            uart_auxiliary_line_o <= 1'b0;
        end else begin
            uart_request_line_o   <= uart_sideband_enable_i && (ustate_reg != shrp_pkg::U_ADDR);
            uart_auxiliary_line_o <= uart_sideband_enable_i && rx_busy_reg;
        end
    end

    // ---- shared register port; only one interface is ever active
    wire        rd_req  = spi_rd_req || uart_rd_req;
    // uart address bits 5..0, bit 6 ignored
    wire [5:0]  rd_addr = spi_rd_req ? spi_baddr
                                     : rx_sh_reg[shrp_pkg::UART_A_MSB:shrp_pkg::UART_A_LSB];
    wire        push_v  = spi_push || uart_push;
    wire [13:0] push_d  = spi_push ? {spi_addr_reg, spi_byte}
                                   : {u_addr_reg[shrp_pkg::UART_A_MSB:shrp_pkg::UART_A_LSB], u_data_reg};
    wire [13:0] buf_out;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rd_o      <= 1'b0;
            reg_rd_addr_o <= 6'h00;
            rd_ack_reg    <= 1'b0;
            wr_drop_o     <= 1'b0;
        end else begin
            reg_rd_o   <= rd_req;
            rd_ack_reg <= reg_rd_o;
            // spi cannot be stalled, so a full buffer drops the byte
            wr_drop_o  <= spi_push && !buf_ready;
            if (rd_req) begin
                reg_rd_addr_o <= rd_addr;
            end
        end
    end

    shrp_buf2 #(
        .W (14)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_v),
        .in_ready_o  (buf_ready),
        .in_data_i   (push_d),
        .out_valid_o (reg_wr_valid_o),
        .out_ready_i (reg_wr_ready_i),
        .out_data_o  (buf_out)
    );

    assign reg_wr_addr_o = buf_out[13:8];
    assign reg_wr_data_o = buf_out[7:0];

    // ---- checks
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd_issue;
        ##1 reg_rd_o ##1 rd_ack_reg;
    endsequence
    sequence s_push_ack;
        (ustate_reg == shrp_pkg::U_PUSH) && buf_ready;
    endsequence
    sequence s_ack_start;
        tx_busy_reg && !uart_tx_o ##1 tx_busy_reg;
    endsequence

    spi_rd_a: assert property (spi_rd_req |=> reg_rd_o && reg_rd_addr_o == $past(spi_baddr))
        else $error("spi read not issued");
    spi_addr_a: assert property (spi_done && spi_first_reg |=> spi_addr_reg == $past(spi_baddr))
        else $error("spi address not latched");
    spi_wr_a: assert property (spi_push && !reg_wr_valid_o |=> reg_wr_valid_o && reg_wr_data_o == $past(spi_byte) && reg_wr_addr_o == $past(spi_addr_reg))
        else $error("spi write byte lost");
    miso_hold_a: assert property (!sck_fall |=> $stable(spi_miso_o))
        else $error("miso moved off falling edge");
    nss_reset_a: assert property (!spi_act |=> spi_first_reg && spi_bit_reg == 3'h0)
        else $error("deselect did not restart");
    rate_dflt_a: assert property ($fell(rst_i) |-> bit_ticks == shrp_pkg::DFLT_TICKS)
        else $error("default rate wrong");
    uart_rd_a: assert property (uart_rd_req |-> s_rd_issue ##0 tx_start)
        else $error("uart read answer missing");
    uart_ack_a: assert property (s_push_ack |=> s_ack_start)
        else $error("write acknowledge not sent");
    tx_stop_a: assert property ($fell(tx_busy_reg) |-> uart_tx_o && $past(uart_tx_o))
        else $error("stop bit missing");
    sideband_off_a: assert property (!uart_sideband_enable_i |=> !uart_request_line_o && !uart_auxiliary_line_o)
        else $error("sideband active while disabled");
    strap_excl_a: assert property (strap_cnt_reg == shrp_pkg::STRAP_DONE |=> !(if_spi_o && if_uart_o) && $stable(if_spi_o) && $stable(if_uart_o))
        else $error("two interfaces enabled");
endmodule

// ==== rtl/shrp_sync.sv ====
module shrp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // two flops per lane; first flop feeds only the second
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        logic meta_reg;
        logic sync_reg;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta_reg <= RST_VAL[i];
                sync_reg <= RST_VAL[i];
            end else begin
                meta_reg <= d_i[i];
                sync_reg <= meta_reg;
            end
        end
        assign q_o[i] = sync_reg;
    end
endmodule

// ==== verif/shrp_host.sv ====
module shrp_host (
    output logic      sck_o,
    output logic      mosi_o,
    output logic      nss_n_o,
    output logic      rx_o,
    input  wire logic miso_i,
    input  wire logic tx_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: sck low, deselected, rx at stop level
    initial begin
        {sck_o, mosi_o, nss_n_o, rx_o} = 4'b0011;
    end
    task automatic spi_sel(input logic on);
        nss_n_o = ~on;
        // released mosi flips so a stale level never looks valid
        if (!on) mosi_o = ~mosi_o;
        #100;
    endtask
    task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = d[i];
            #50 sck_o = 1'b1;
            q[i] = miso_i;
            #50 sck_o = 1'b0;
        end
    endtask
    task automatic uart_put(input logic [7:0] d, input realtime bt);
        for (int i = 0; i < 10; i++) begin
            rx_o = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
            #bt;
        end
    endtask
    // whole frame sampled at bit centres, start bit first
    task automatic uart_get(output logic [9:0] q, input realtime bt);
        @(negedge tx_i);
        #(bt / 2);
        for (int i = 0; i < 10; i++) begin
            q[i] = tx_i;
            #bt;
        end
    endtask
endmodule

// ==== verif/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ea = 1'b1;
    logic        i2c = 1'b0;
    logic        sb_en = 1'b1;
    logic        rate_wr_i = 1'b0;
    logic [7:0]  rate_data_i = 8'h00;
    logic [7:0]  rdata = 8'h00;
    logic        ready = 1'b0;
    wire         sck, mosi, nss_n, rx, miso, tx, req, aux, if_spi, if_uart, rd, wv, drop;
    wire  [5:0]  rd_a, wa;
    wire  [7:0]  rate, wd;
    logic [13:0] wq[$];
    logic [9:0]  q;
    logic [7:0]  b;
    int          miscompares = 0;
    int          n_tests = 0;
    int          drops = 0;
    int          cyc = 0;
    shrp_host host_u (.sck_o(sck), .mosi_o(mosi), .nss_n_o(nss_n), .rx_o(rx), .miso_i(miso), .tx_i(tx));
    shrp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_nss_n_i(nss_n),
        .spi_miso_o(miso), .uart_rx_i(rx), .uart_tx_o(tx), .uart_request_line_o(req),
        .uart_auxiliary_line_o(aux), .uart_sideband_enable_i(sb_en), .strap_i2c_i(i2c), .strap_ea_i(ea),
        .if_spi_o(if_spi), .if_uart_o(if_uart), .rate_wr_i(rate_wr_i), .rate_data_i(rate_data_i),
        .uart_rate_register_o(rate), .reg_rd_o(rd), .reg_rd_addr_o(rd_a), .reg_rdata_i(rdata),
        .reg_wr_valid_o(wv), .reg_wr_ready_i(ready), .reg_wr_addr_o(wa), .reg_wr_data_o(wd), .wr_drop_o(drop));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // register file stand-in, drop counter and hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rd === 1'b1) rdata <= ~{2'b00, rd_a};
        if (wv === 1'b1 && ready === 1'b1) wq.push_back({wa, wd});
        if (drop === 1'b1) drops <= drops + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic e);
        ea = e;
        rst_i = 1'b1;
        step(10);
        rst_i = 1'b0;
        step(8);
    endtask
    task automatic set_rate(input logic [7:0] v);
        step(1);
        rate_data_i = v;
        rate_wr_i = 1'b1;
        step(1);
        rate_wr_i = 1'b0;
        step(1);
        chk("rate", 16'(v), 16'(rate));
    endtask
    // buffer fills with the far side stalled, third data byte is lost
    task automatic t_spi_write;
        logic [7:0] wb[4] = '{8'h0a, 8'h11, 8'h22, 8'h33};
        host_u.spi_sel(1'b1);
        foreach (wb[i]) begin
            host_u.spi_byte(wb[i], b);
            chk("miso wr", 16'h0000, 16'(b));
        end
        host_u.spi_sel(1'b0);
        step(4);
        chk("drops", 16'h0001, 16'(drops));
        chk("head", {1'b0, 1'b1, 6'h05, 8'h11}, {1'b0, wv, wa, wd});
        ready = 1'b1;
        step(4);
        chk("wr0", {2'b00, 6'h05, 8'h11}, 16'(wq[0]));
        chk("wr1", {2'b00, 6'h05, 8'h22}, 16'(wq[1]));
        chk("drained", 16'h0000, 16'(wv));
        $display("end spi write");
    endtask
    // a fresh burst starts at an address byte; data lags a byte
    task automatic t_spi_read;
        host_u.spi_sel(1'b1);
        host_u.spi_byte(8'h82, b);
        host_u.spi_byte(8'h84, b);
        chk("rd a1", 16'h00fe, 16'(b));
        host_u.spi_byte(8'h00, b);
        chk("rd a2", 16'h00fd, 16'(b));
        host_u.spi_sel(1'b0);
        $display("end spi read");
    endtask
    task automatic uart_read(input logic [7:0] a, input realtime bt, input logic sb);
        step(1);
        sb_en = sb;
        step(2);
        fork
            host_u.uart_get(q, bt);
            begin
                host_u.uart_put(a, bt);
                chk("request", 16'(sb), 16'(req));
            end
            begin
                #(bt * 5);
                chk("aux", 16'(sb), 16'(aux));
            end
        join
        chk("answer", 16'({1'b1, ~{2'b00, a[5:0]}, 1'b0}), 16'(q));
    endtask
    task automatic t_uart;
        i2c = 1'b1;
        do_reset(1'b0);
        chk("no sel", 16'h0000, 16'({if_spi, if_uart}));
        i2c = 1'b0;
        do_reset(1'b0);
        chk("uart sel", 16'h0001, 16'({if_spi, if_uart}));
        chk("rate rst", 16'h00eb, 16'(rate));
        set_rate(8'h15);
        wq.delete();
        fork
            host_u.uart_get(q, 22000.0 / 27.12);
            begin
                host_u.uart_put(8'h05, 22000.0 / 27.12);
                host_u.uart_put(8'haa, 22000.0 / 27.12);
            end
        join
        chk("echo", 16'h020a, 16'(q));
        chk("uart wr", {2'b00, 6'h05, 8'haa}, 16'(wq[0]));
        uart_read(8'hc3, 22000.0 / 27.12, 1'b1);
        set_rate(8'h3a);
        uart_read(8'h84, 59000.0 / 27.12, 1'b0);
        $display("end uart");
    endtask
    initial begin
        do_reset(1'b1);
        chk("spi sel", 16'h0002, 16'({if_spi, if_uart}));
        t_spi_write();
        t_spi_read();
        t_uart();
        give_verdict();
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
endmodule
